// ===== instruction_word_decoder.sv
// Instruction word decoder with cycle framing and branch no-operation flush.
`timescale 1ns/1ps
`default_nettype none
module instruction_word_decoder
#(
	parameter int WORD_W = instr_decode_pkg::WORD_W
)
(
	input wire logic clk, // Oscillator clock, 40 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [WORD_W-1:0] fetch_word, // Word from program memory.
	input wire logic cond_true, // Skip test result from the datapath.
	output logic [1:0] op_group, // Decoded group of the current word.
	output logic [5:0] byte_opcode, // Opcode of byte or literal ops.
	output logic [3:0] bit_opcode, // Opcode of bit ops.
	output logic [2:0] jump_opcode, // Opcode of call or jump.
	output logic [6:0] file_addr, // File register address.
	output logic [2:0] bit_index, // Bit select within a register.
	output logic dest_file, // High: result to file, low: accumulator.
	output logic [7:0] literal8, // Eight-bit immediate value.
	output logic [10:0] target11, // Eleven-bit jump or call target.
	output logic is_call, // Current word is a subroutine call.
	output logic is_flush, // Current cycle runs as no-operation.
	output logic legacy_load, // Current word is a legacy load.
	output logic cycle_start, // Pulse, first period of a cycle.
	output logic [1:0] phase_out // Oscillator period within the cycle.
);
	logic [1:0] phase;
	logic cycle_end;
	logic [WORD_W-1:0] word;
	logic [WORD_W-1:0] next_word;
	logic flush;
	logic next_flush;
	logic [1:0] next_op_group;
	logic [5:0] next_byte_opcode;
	logic [3:0] next_bit_opcode;
	logic [2:0] next_jump_opcode;
	logic [6:0] next_file_addr;
	logic [2:0] next_bit_index;
	logic next_dest_file;
	logic [7:0] next_literal8;
	logic [10:0] next_target11;
	logic next_is_call;
	logic next_is_flush;
	logic next_legacy_load;
	logic next_cycle_start;
	logic [1:0] next_phase_out;
	logic two_cycle;

	// ==========================================================
	// Cycle framing
	cycle_phase u_phase
	(
		.clk(clk),
		.rst(rst),
		.phase(phase),
		.cycle_end(cycle_end)
	);

	// Small field extractors; the flush decision and the output decode share
	// them, though both also write some of the same bit slices out inline.
	function automatic logic [1:0] group_of(input logic [WORD_W-1:0] w);
		return w[instr_decode_pkg::GRP_HI:instr_decode_pkg::GRP_LO];
	endfunction

	function automatic logic [5:0] byte_op_of(input logic [WORD_W-1:0] w);
		return w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BYTE_OP_LO];
	endfunction

	function automatic logic [3:0] bit_op_of(input logic [WORD_W-1:0] w);
		return w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BIT_OP_LO];
	endfunction

	function automatic logic [7:0] low_byte_of(input logic [WORD_W-1:0] w);
		return w[instr_decode_pkg::LOW_BYTE_HI:0];
	endfunction

	// Decide whether the word just executed changes the counter or skips.
	// Skips depend on the datapath test; jumps and returns always flush.
	function automatic logic needs_second(input logic [WORD_W-1:0] w, input logic c);
		logic [1:0] g;
		g = group_of(w);
		needs_second = 1'b0;
		case (g)
			instr_decode_pkg::GRP_JUMP:
				needs_second = 1'b1;
			instr_decode_pkg::GRP_LIT:
				needs_second = (bit_op_of(w) == instr_decode_pkg::OP_RETLW);
			instr_decode_pkg::GRP_BIT:
				needs_second = c &&
					(w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BIT_OP_LO]
						== instr_decode_pkg::OP_BTFSC ||
					w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BIT_OP_LO]
						== instr_decode_pkg::OP_BTFSS);
			default:
			begin
				if (w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BYTE_OP_LO]
					== instr_decode_pkg::OP_MISC)
					needs_second = w[instr_decode_pkg::LOW_BYTE_HI:0]
						== instr_decode_pkg::LOW_RETURN ||
						w[instr_decode_pkg::LOW_BYTE_HI:0]
						== instr_decode_pkg::LOW_RETFIE;
				else
					needs_second = c &&
						(w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BYTE_OP_LO]
							== instr_decode_pkg::OP_DECFSZ ||
						w[instr_decode_pkg::GRP_HI:instr_decode_pkg::BYTE_OP_LO]
							== instr_decode_pkg::OP_INCFSZ);
			end
		endcase
	endfunction

	// ==========================================================
	// Word capture and flush sequencing
	// two cycle decision
	assign two_cycle = !flush && needs_second(word, cond_true);

	always_comb
	begin
		next_word = word;
		next_flush = flush;
		if (cycle_end)
		begin
			// discard prefetched word
			// The prefetched word is replaced by a no-operation, so a taken
			// branch never lets the fall-through instruction act.
			next_flush = two_cycle;
			next_word = two_cycle ? instr_decode_pkg::NOP_WORD : fetch_word;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			word <= instr_decode_pkg::NOP_WORD;
			flush <= 1'b0;
		end
		else
		begin
			word <= next_word;
			flush <= next_flush;
		end
	end

	// ==========================================================
	// Field decode
	always_comb
	begin
		next_op_group = group_of(word);
		next_byte_opcode = byte_op_of(word);
		next_bit_opcode = bit_op_of(word);
		next_bit_index = word[instr_decode_pkg::BIT_IDX_HI:instr_decode_pkg::BIT_IDX_LO];
		next_jump_opcode = word[instr_decode_pkg::GRP_HI:instr_decode_pkg::JUMP_OP_LO];
		next_target11 = word[instr_decode_pkg::TARGET_HI:0];
		next_is_call = (next_op_group == instr_decode_pkg::GRP_JUMP) &&
			!word[instr_decode_pkg::CALL_SEL_BIT];
		next_file_addr = word[instr_decode_pkg::FILE_HI:0];
		next_literal8 = word[instr_decode_pkg::LIT_HI:0];
		next_dest_file = instr_decode_pkg::DEST_FILE;
		if (next_op_group == instr_decode_pkg::GRP_BYTE)
			next_dest_file = word[instr_decode_pkg::DEST_BIT];
		// don't-care bits compared
		// The exact low byte must match for the legacy loads; bit 5 and the
		// other don't-care positions take part in the compare like any other bit.
		next_legacy_load = (next_byte_opcode == instr_decode_pkg::OP_MISC) &&
			(low_byte_of(word) == instr_decode_pkg::LOW_OPTION ||
			low_byte_of(word) == instr_decode_pkg::LOW_DIRLOAD_A ||
			low_byte_of(word) == instr_decode_pkg::LOW_DIRLOAD_B);
		next_is_flush = flush;
		next_cycle_start = cycle_end;
		next_phase_out = phase + 2'h1;
	end

	// Outputs are registered; they trail the internal word by one clock.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			op_group <= instr_decode_pkg::GRP_BYTE;
			byte_opcode <= 6'h00;
			bit_opcode <= 4'h0;
			jump_opcode <= 3'h0;
			file_addr <= 7'h00;
			bit_index <= 3'h0;
			dest_file <= instr_decode_pkg::DEST_ACC;
			literal8 <= 8'h00;
			target11 <= 11'h000;
			is_call <= 1'b0;
			is_flush <= 1'b0;
			legacy_load <= 1'b0;
			cycle_start <= 1'b0;
			phase_out <= instr_decode_pkg::PHASE_FIRST;
		end
		else
		begin
			op_group <= next_op_group;
			byte_opcode <= next_byte_opcode;
			bit_opcode <= next_bit_opcode;
			jump_opcode <= next_jump_opcode;
			file_addr <= next_file_addr;
			bit_index <= next_bit_index;
			dest_file <= next_dest_file;
			literal8 <= next_literal8;
			target11 <= next_target11;
			is_call <= next_is_call;
			is_flush <= next_is_flush;
			legacy_load <= next_legacy_load;
			cycle_start <= next_cycle_start;
			phase_out <= next_phase_out;
		end
	end

	// ==========================================================
	// Checks
	// A jump or call executing at a take edge outside a flush.
	sequence s_jump_taken;
		cycle_end && !flush && group_of(word) == instr_decode_pkg::GRP_JUMP;
	endsequence

	// A bit test whose skip condition is true at a take edge.
	sequence s_bit_skip;
		cycle_end && !flush && cond_true &&
			(bit_op_of(word) == instr_decode_pkg::OP_BTFSC ||
			bit_op_of(word) == instr_decode_pkg::OP_BTFSS);
	endsequence

	// One clock of the forced no-operation cycle.
	sequence s_nop_cycle;
		flush && word == instr_decode_pkg::NOP_WORD;
	endsequence

	a_jump_flushes: assert property (@(posedge clk) disable iff (rst)
		s_jump_taken |=> s_nop_cycle [*4])
		else $error("jump not followed by no-operation cycle");

	a_skip_flushes: assert property (@(posedge clk) disable iff (rst)
		s_bit_skip |=> s_nop_cycle [*4])
		else $error("taken bit test not followed by no-operation cycle");

	a_flush_once: assert property (@(posedge clk) disable iff (rst)
		flush && cycle_end |=> !flush)
		else $error("flush lasted more than one cycle");

	a_word_steady: assert property (@(posedge clk) disable iff (rst)
		!cycle_end |=> $stable(word))
		else $error("word changed inside a cycle");

	a_fetch_taken: assert property (@(posedge clk) disable iff (rst)
		cycle_end && !two_cycle |=> word == $past(fetch_word))
		else $error("fetched word not loaded");

	a_dest_select: assert property (@(posedge clk) disable iff (rst)
		group_of(word) == instr_decode_pkg::GRP_BYTE |=>
			dest_file == $past(word[instr_decode_pkg::DEST_BIT]))
		else $error("destination select wrong");

	a_dest_default: assert property (@(posedge clk) disable iff (rst)
		group_of(word) != instr_decode_pkg::GRP_BYTE |=> dest_file)
		else $error("absent destination not file");

	a_bit_fields: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> bit_index ==
			$past(word[instr_decode_pkg::BIT_IDX_HI:instr_decode_pkg::BIT_IDX_LO]) &&
			file_addr == $past(word[instr_decode_pkg::FILE_HI:0]))
		else $error("bit fields wrong");

	a_target_field: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> target11 == $past(word[instr_decode_pkg::TARGET_HI:0]) &&
			jump_opcode == $past(word[instr_decode_pkg::GRP_HI:instr_decode_pkg::JUMP_OP_LO]))
		else $error("jump fields wrong");

	a_start_pulse: assert property (@(posedge clk) disable iff (rst)
		cycle_start |=> !cycle_start [*3] ##1 cycle_start)
		else $error("cycle start not every four clocks");

	a_group_field: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> op_group ==
			$past(word[instr_decode_pkg::GRP_HI:instr_decode_pkg::GRP_LO]))
		else $error("group field wrong");

	a_byte_fields: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> byte_opcode ==
			$past(word[instr_decode_pkg::GRP_HI:instr_decode_pkg::BYTE_OP_LO]))
		else $error("byte opcode field wrong");

	a_literal_field: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> literal8 == $past(word[instr_decode_pkg::LIT_HI:0]))
		else $error("literal field wrong");

	a_flush_shown: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> is_flush == $past(flush))
		else $error("flush flag does not follow the flush cycle");

	a_call_flag: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> is_call == $past(group_of(word) == instr_decode_pkg::GRP_JUMP &&
			!word[instr_decode_pkg::CALL_SEL_BIT]))
		else $error("call flag wrong");
endmodule
`default_nettype wire

// ===== instr_decode_pkg.sv
// Constants, field layouts and opcode groups for the instruction word decoder.
// Operation
// - Each fetched instruction is one 14-bit word, bit 13 most significant.
// - File operand is 7 bits, addressing registers 0x00 through 0x7F.
// - Byte ops: opcode bits 13..8, destination bit 7, file address 6..0.
// - Destination 0 writes the accumulator, 1 writes the file register.
// - Bit ops: opcode 13..10, bit index 9..7, file address 6..0.
// - Literal ops: opcode 13..8, 8-bit immediate in bits 7..0.
// - Call and jump: 3-bit opcode 13..11, 11-bit target 10..0.
// - Don't-care bits decode the same whether 0 or 1; the legacy load decode compares the exact low byte.
// - One cycle per instruction; taken test or counter change makes two.
// - The second cycle runs as no-operation, discarding the prefetched word.
// - An instruction cycle spans four oscillator periods.
// - Top bits 00 byte, 01 bit, 10 call or jump, 11 literal.
package instr_decode_pkg;
	// ==========================================================
	// Word and field layout
	localparam int WORD_W = 14;
	localparam int GRP_HI = 13;
	localparam int GRP_LO = 12;
	localparam int BYTE_OP_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int FILE_HI = 6;
	localparam int FILE_W = 7;
	localparam int BIT_OP_LO = 10;
	localparam int BIT_IDX_HI = 9;
	localparam int BIT_IDX_LO = 7;
	localparam int LIT_HI = 7;
	localparam int JUMP_OP_LO = 11;
	localparam int TARGET_HI = 10;
	localparam int CALL_SEL_BIT = 11;
	localparam int LOW_BYTE_HI = 7;
	// ==========================================================
	// Timing
	localparam int PHASES = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_FIRST = 2'h0;
	// ==========================================================
	// Opcode groups and selected encodings
	typedef enum logic [1:0]
	{
		GRP_BYTE = 2'b00,
		GRP_BIT = 2'b01,
		GRP_JUMP = 2'b10,
		GRP_LIT = 2'b11
	} group_e;
	localparam logic [5:0] OP_MISC = 6'h00;
	localparam logic [5:0] OP_DECFSZ = 6'h0B;
	localparam logic [5:0] OP_INCFSZ = 6'h0F;
	localparam logic [3:0] OP_BTFSC = 4'h6;
	localparam logic [3:0] OP_BTFSS = 4'h7;
	localparam logic [3:0] OP_RETLW = 4'hD;
	localparam logic [7:0] LOW_RETURN = 8'h08;
	localparam logic [7:0] LOW_RETFIE = 8'h09;
	localparam logic [7:0] LOW_OPTION = 8'h62;
	localparam logic [7:0] LOW_DIRLOAD_A = 8'h65;
	localparam logic [7:0] LOW_DIRLOAD_B = 8'h67;
	localparam logic [1:0] LIT_RETLW_TOP = 2'h1;
	localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;
endpackage

// ===== cycle_phase.sv
// Divide-by-four phase counter that frames each instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module cycle_phase
(
	input wire logic clk, // Oscillator clock.
	input wire logic rst, // Synchronous reset, active high.
	output logic [1:0] phase, // Current oscillator period within a cycle.
	output logic cycle_end // High in the last period of a cycle.
);
	logic [1:0] next_phase;

	// ==========================================================
	// Phase counter
	// four oscillator periods
	always_comb
	begin
		next_phase = phase + 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			phase <= instr_decode_pkg::PHASE_FIRST;
		else
			phase <= next_phase;
	end

	assign cycle_end = (phase == instr_decode_pkg::PHASE_LAST);

	// The phase wraps back to zero right after the last period.
	a_phase_wrap: assert property (@(posedge clk) disable iff (rst)
		cycle_end |=> phase == instr_decode_pkg::PHASE_FIRST)
		else $error("phase did not wrap after last period");
endmodule
`default_nettype wire

// ===== prog_mem_model.sv
// Program memory model that offers one instruction word per cycle.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
	input wire logic clk, // Oscillator clock.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [13:0] word_in, // Next word chosen by the bench.
	output logic [13:0] fetch_word // Word offered to the decoder.
);
	logic [1:0] slot = 2'h0;
	// ==========================================================
	// Fetch slot tracking
	// Follows the decoder's period count so a word is offered only in its slot.
	always @(posedge clk)
	begin
		slot <= rst ? 2'h0 : slot + 2'h1;
	end
	// whole word
	// Outside the slot the bus toggles, so a mistimed sample cannot pass.
	initial fetch_word = 14'h0000;
	always @(posedge clk)
	begin
		#3;
		fetch_word = (slot == 2'h3) ? word_in : ~fetch_word;
	end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the instruction word decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cond_true = 1'b0;
	logic [13:0] word_in = 14'h0000;
	logic [13:0] fetch_word;
	logic [1:0] op_group;
	logic [5:0] byte_opcode;
	logic [3:0] bit_opcode;
	logic [2:0] jump_opcode;
	logic [6:0] file_addr;
	logic [2:0] bit_index;
	logic dest_file;
	logic [7:0] literal8;
	logic [10:0] target11;
	logic is_call;
	logic is_flush;
	logic legacy_load;
	logic cycle_start;
	logic [1:0] phase_out;
	logic [31:0] seed = 32'h00007016;
	int error_cnt = 0;
	int check_count = 0;
	logic [14:0] exp_q[$];
	logic [14:0] last = 15'h0000;
	logic [15:0] gap = 16'h0000;
	logic started = 1'b0;
	logic due = 1'b0;
	// directed words
	// A filler after each redirecting word is discarded, so the next one executes.
	logic [13:0] dir_tab [16] = '{14'h0062, 14'h0065, 14'h0067, 14'h0008, 14'h1234, 14'h0009,
		14'h0000, 14'h3400, 14'h0000, 14'h3700, 14'h0000, 14'h2800, 14'h0000, 14'h2000,
		14'h0000, 14'h0B85};

	prog_mem_model mem_u (.clk(clk), .rst(rst), .word_in(word_in), .fetch_word(fetch_word));
	instruction_word_decoder #(.WORD_W(14)) dut_u (.clk(clk), .rst(rst),
		.fetch_word(fetch_word), .cond_true(cond_true), .op_group(op_group),
		.byte_opcode(byte_opcode), .bit_opcode(bit_opcode), .jump_opcode(jump_opcode),
		.file_addr(file_addr), .bit_index(bit_index), .dest_file(dest_file),
		.literal8(literal8), .target11(target11), .is_call(is_call), .is_flush(is_flush),
		.legacy_load(legacy_load), .cycle_start(cycle_start), .phase_out(phase_out));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// Jumps, calls and returns always redirect; skip tests only when true.
	function automatic logic redirect(input logic [13:0] w, input logic c);
		return w[13:12] == 2'b10 || w == 14'h0008 || w == 14'h0009 || w[13:10] == 4'hD
			|| (c && (w[13:8] == 6'h0B || w[13:8] == 6'h0F || w[13:11] == 3'b011));
	endfunction
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (error_cnt == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Offers a word for the next fetch slot and notes what must execute.
	task automatic take(input logic [13:0] w);
		repeat (3) @(posedge clk);
		#2;
		seed = xs(seed);
		word_in = w;
		cond_true = seed[0];
		@(posedge clk);
		if (!last[14] && redirect(last[13:0], cond_true))
			last = {1'b1, 14'h0000};
		else
			last = {1'b0, w};
		exp_q.push_back(last);
		if (!started)
			gap = 16'h0003;
		started = 1'b1;
	endtask
	task automatic cmp(input logic [14:0] e);
		logic [13:0] w;
		w = e[13:0];
		chk("opcodes", {op_group, byte_opcode, bit_opcode, jump_opcode, 1'b0},
			{w[13:12], w[13:8], w[13:10], w[13:11], 1'b0});
		chk("fields", {2'h0, bit_index, file_addr}, {2'h0, w[9:7], w[6:0]});
		chk("dest", {15'h0000, dest_file},
			{15'h0000, (w[13:12] == 2'b00) ? w[7] : 1'b1});
		chk("literal8", {8'h00, literal8}, {8'h00, w[7:0]});
		chk("target11", {5'h00, target11}, {5'h00, w[10:0]});
		chk("flags", {13'h0000, is_call, is_flush, legacy_load}, {13'h0000, w[13:11] == 3'b100,
			e[14], w == 14'h0062 || w == 14'h0065 || w == 14'h0067});
	endtask

	// ==========================================================
	// Clock and stimulus
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		#2;
		rst = 1'b0;
		foreach (dir_tab[i])
			take(dir_tab[i]);
		repeat (200)
		begin
			seed = xs(seed);
			take(seed[13:0]);
		end
		// Stop before the next fetch slot, which would take an unplanned word.
		repeat (2) @(posedge clk);
		chk("pending", 16'(exp_q.size()), 16'h0000);
		complete_run();
	end
	// Watches the outputs mid-cycle; more than eight clocks without a cycle start end the run.
	// The start pulse leads the decoded fields by one clock, so the note
	// is compared at the falling edge after the pulse.
	always @(negedge clk)
	begin
		if (started)
		begin
			gap = gap + 16'h0001;
			if (due)
			begin
				due = 1'b0;
				if (exp_q.size() == 0)
					chk("queue", 16'h0001, 16'h0000);
				else
					cmp(exp_q.pop_front());
			end
			if (cycle_start === 1'b1)
			begin
				due = 1'b1;
				chk("phase", {14'h0000, phase_out}, 16'h0000);
				chk("cycle_gap", gap, 16'h0004);
				gap = 16'h0000;
			end
			if (gap > 16'h0008)
			begin
				error_cnt++;
				complete_run();
			end
		end
	end
endmodule
`default_nettype wire
